// ---- hw/rmb_pkg.sv ----
// constants and types shared by the radio modem baud and buffer block
package rmb_pkg;
  // word index of each register; byte address is four times the index
  localparam int ADR_W = 12;
  localparam logic [9:0] IDX_BUF = 10'h0c9;
  localparam logic [9:0] IDX_MODEM = 10'h0db;
  localparam logic [9:0] IDX_CTRL = 10'h0c0;
  localparam logic [9:0] IDX_STAT = 10'h0c1;

  // reset values: both chains powered down, nrz, slowest rate
  localparam logic [7:0] RST_BUF = 8'h00;
  localparam logic [7:0] RST_MODEM = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h06;

  // control register bit positions
  localparam int CTRL_BYTE = 0;
  localparam int CTRL_TXPD = 1;
  localparam int CTRL_RXPD = 2;
  localparam int CTRL_DIR = 3;
  localparam int CTRL_IEN = 4;
  localparam logic [7:0] CTRL_MASK = 8'h1f;

  // status register bit positions
  localparam int STAT_IRQ = 0;
  localparam int STAT_VIOL = 1;

  // data coding codes
  localparam logic [1:0] CODE_NRZ = 2'h0;
  localparam logic [1:0] CODE_MANCH = 2'h1;
  localparam logic [1:0] CODE_TRANS = 2'h2;
  localparam logic [1:0] CODE_UART = 2'h3;

  // highest valid rate and crystal codes
  localparam logic [2:0] BAUD_MAX = 3'h5;
  localparam logic [2:0] XTAL_MAX = 3'h5;

  // reference crystal 3686.4 kHz and base rate 0.6 kBaud, both in 0.1 kHz
  localparam int REF_KHZ_X10 = 36864;
  localparam int BASE_KBAUD_X10 = 6;
  localparam int BASE_DIV = REF_KHZ_X10 / BASE_KBAUD_X10;
  localparam int BYTE_BITS = 8;

  // layout of the rate and format control register
  typedef struct packed {
    logic [2:0] baud;
    logic [1:0] coding;
    logic [2:0] xtal;
  } rmb_modem_t;

  typedef enum logic [1:0] {
    TX_OFF = 2'b01,
    TX_RUN = 2'b10
  } rmb_tx_state_t;
endpackage

// ---- hw/rmb_baud_gen.sv ----
// symbol rate tick generator driven from the crystal clock
`timescale 1ns/10ps
`default_nettype none
module rmb_baud_gen
  import rmb_pkg::*;
#(
  parameter int BASE_DIV = rmb_pkg::BASE_DIV
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic run_i,
  input wire logic [2:0] baud_code_i,
  input wire logic [2:0] xtal_code_i,
  input wire logic resync_i,
  output logic tick_o
);
  logic [2:0] baud_eff;
  logic [2:0] xtal_eff;
  logic [15:0] unit;
  logic [15:0] period;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;

  // unused codes clamp to the nearest valid setting
  assign baud_eff = (baud_code_i > BAUD_MAX) ? BAUD_MAX : baud_code_i;
  assign xtal_eff = (xtal_code_i > XTAL_MAX) ? XTAL_MAX : xtal_code_i;
  // period = base / 2^baud * (xtal + 1) crystal cycles
  assign unit = 16'(BASE_DIV >> baud_eff);
  assign period = 16'(32'(unit) * (32'(xtal_eff) + 32'h1));
  assign tick_o = run_i && ce_i && (cnt_q == 16'h0000);

  // down counter; a data edge re-centres the sampling point
  assign cnt_d = !run_i ? period - 16'h0001 :
                 resync_i ? (period >> 1) :
                 (cnt_q == 16'h0000) ? period - 16'h0001 :
                 cnt_q - 16'h0001;

  // counter register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 16'h0000;
    end else if (ce_i) begin
      cnt_q <= cnt_d;
    end
  end

  a_tick_spacing: assert property (@(posedge clk_i) disable iff (rst_i)
    tick_o && !resync_i |=> !tick_o)
    else $error("symbol ticks closer than two clocks");
endmodule
`default_nettype wire

// ---- hw/rmb_modem.sv ----
// radio modem data path: rate select, coding, buffer and shift register
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module rmb_modem
  import rmb_pkg::*;
#(
  parameter int BASE_DIV = rmb_pkg::BASE_DIV
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  output logic irq_o,
  output logic tx_mod_o,
  input wire logic rx_demod_i,
  input wire logic uart_tx_i,
  output logic uart_rx_o
);
  // word select from a bus address
  function automatic logic hit(input logic [ADR_W-1:0] adr,
                               input logic [9:0] idx);
    hit = (adr[ADR_W-1:2] == idx);
  endfunction

  logic [7:0] radio_data_buffer_q;
  rmb_modem_t modem_rate_format_control_q;
  logic [7:0] ctrl_q;
  logic radio_irq_flag_q;
  logic coding_violation_flag_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic req;
  logic wr_low;
  logic wr_buf;
  logic wr_modem;
  logic wr_ctrl;
  logic wr_stat;
  logic [7:0] rd_byte;

  // register bus decode
  assign req = cyc_i && stb_i;
  assign wr_low = req && we_i && ack_q && sel_i[0] && ce_i;
  assign wr_buf = wr_low && hit(adr_i, IDX_BUF);
  assign wr_modem = wr_low && hit(adr_i, IDX_MODEM);
  assign wr_ctrl = wr_low && hit(adr_i, IDX_CTRL);
  assign wr_stat = wr_low && hit(adr_i, IDX_STAT);
  assign rd_byte = hit(adr_i, IDX_BUF) ? radio_data_buffer_q :
                   hit(adr_i, IDX_MODEM) ? modem_rate_format_control_q :
                   hit(adr_i, IDX_CTRL) ? ctrl_q :
                   hit(adr_i, IDX_STAT) ?
                     {6'h00, coding_violation_flag_q, radio_irq_flag_q} :
                   8'h00;
  assign ack_o = ack_q;
  assign dat_o = dat_q;

  // one wait state, read data captured on the same edge that raises the acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_q <= req && !ack_q;
      if (req && !ack_q) begin
        dat_q <= {24'h00_0000, rd_byte};
      end
    end
  end

  // mode decode
  logic byte_transfer_select;
  logic transmit_chain_powerdown;
  logic radio_irq_enable;
  logic tx_run;
  logic rx_run;
  logic is_sync;
  logic is_manch;
  logic is_trans;
  logic is_uart;

  assign byte_transfer_select = ctrl_q[CTRL_BYTE];
  assign transmit_chain_powerdown = ctrl_q[CTRL_TXPD];
  assign radio_irq_enable = ctrl_q[CTRL_IEN];
  assign tx_run = ctrl_q[CTRL_DIR] && !transmit_chain_powerdown;
  assign rx_run = !ctrl_q[CTRL_DIR] && !ctrl_q[CTRL_RXPD];
  assign is_sync = !modem_rate_format_control_q.coding[1];
  assign is_manch = modem_rate_format_control_q.coding == CODE_MANCH;
  assign is_trans = modem_rate_format_control_q.coding == CODE_TRANS;
  assign is_uart = modem_rate_format_control_q.coding == CODE_UART;

  // demodulator input synchroniser and edge history
  logic rx_s1_q;
  logic rx_s2_q;
  logic rx_s3_q;
  logic rx_edge;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_s1_q <= 1'b0;
      rx_s2_q <= 1'b0;
      rx_s3_q <= 1'b0;
    end else if (ce_i) begin
      rx_s1_q <= rx_demod_i;
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
    end
  end
  assign rx_edge = rx_s2_q != rx_s3_q;

  // symbol clock, re-centred on nrz data edges while receiving
  logic tick;
  logic phase_q;
  logic bit_end;
  logic gen_run;

  assign gen_run = (tx_run || rx_run) && is_sync;

  rmb_baud_gen #(
    .BASE_DIV(BASE_DIV)
  ) u_baud (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .run_i(gen_run),
    .baud_code_i(modem_rate_format_control_q.baud),
    .xtal_code_i(modem_rate_format_control_q.xtal),
    .resync_i(rx_run && !is_manch && rx_edge),
    .tick_o(tick)
  );

  // manchester splits each bit into two chips
  assign bit_end = tick && (!is_manch || phase_q);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_q <= 1'b0;
    end else if (ce_i) begin
      if (!gen_run || !is_manch) begin
        phase_q <= 1'b0;
      end else if (tick) begin
        phase_q <= !phase_q;
      end
    end
  end

  // transmit sequencing
  rmb_tx_state_t tx_state_q;
  rmb_tx_state_t tx_state_d;
  logic [7:0] tx_sh_q;
  logic [2:0] tx_cnt_q;
  logic tx_go;
  logic tx_last;
  logic tx_load;
  logic tx_shift;
  logic tx_mod_q;
  logic tx_mod_d;

  assign tx_go = tx_run && is_sync;
  assign tx_last = !byte_transfer_select || (tx_cnt_q == 3'h7);
  assign tx_load = ce_i && tx_go &&
    ((tx_state_q == TX_OFF) || (bit_end && tx_last));
  assign tx_shift = ce_i && tx_go && (tx_state_q == TX_RUN) &&
                    bit_end && !tx_last;

  always_comb begin
    tx_state_d = tx_state_q;
    unique case (tx_state_q)
      TX_OFF: begin
        if (tx_go) begin
          tx_state_d = TX_RUN;
        end
      end
      TX_RUN: begin
        if (!tx_go) begin
          tx_state_d = TX_OFF;
        end
      end
      default: tx_state_d = TX_OFF;
    endcase
  end

  // shifter reloads from the buffer without disturbing it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_state_q <= TX_OFF;
      tx_sh_q <= 8'h00;
      tx_cnt_q <= 3'h0;
    end else if (ce_i) begin
      tx_state_q <= tx_state_d;
      if (tx_load) begin
        tx_cnt_q <= 3'h0;
        if (byte_transfer_select) begin
          tx_sh_q <= radio_data_buffer_q;
        end else begin
          tx_sh_q <= {radio_data_buffer_q[0], 7'h00};
        end
      end else if (tx_shift) begin
        tx_sh_q <= {tx_sh_q[6:0], 1'b0};
        tx_cnt_q <= tx_cnt_q + 3'h1;
      end
    end
  end

  // modulator drive: bypass modes route straight, else msb of shifter, inverted in the second manchester chip
  assign tx_mod_d = !tx_run ? 1'b0 :
                    is_uart ? uart_tx_i :
                    is_trans ? radio_data_buffer_q[0] :
                    (tx_state_q != TX_RUN) ? 1'b0 :
                    tx_sh_q[7] ^ (is_manch && phase_q);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_mod_q <= 1'b0;
    end else if (ce_i) begin
      tx_mod_q <= tx_mod_d;
    end
  end
  assign tx_mod_o = tx_mod_q;

  // receive path
  logic [7:0] rx_sh_q;
  logic [2:0] rx_cnt_q;
  logic rx_chip_q;
  logic rx_stage_q;
  logic rx_bit;
  logic rx_done;
  logic rx_byte_done;
  logic rx_bit_done;
  logic rx_viol;
  logic uart_rx_q;

  assign rx_bit = is_manch ? rx_chip_q : rx_s2_q;
  assign rx_done = ce_i && rx_run && is_sync && bit_end;
  assign rx_byte_done = rx_done && byte_transfer_select &&
                        (rx_cnt_q == 3'h7);
  assign rx_bit_done = rx_done && !byte_transfer_select;
  assign rx_viol = rx_done && is_manch && (rx_s2_q == rx_chip_q);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_sh_q <= 8'h00;
      rx_cnt_q <= 3'h0;
      rx_chip_q <= 1'b0;
      rx_stage_q <= 1'b0;
      uart_rx_q <= 1'b1;
    end else if (ce_i) begin
      uart_rx_q <= (rx_run && is_uart) ? rx_s2_q : 1'b1;
      if (!rx_run || !is_sync) begin
        rx_cnt_q <= 3'h0;
      end else if (tick && !bit_end) begin
        rx_chip_q <= rx_s2_q;
      end else if (rx_done) begin
        rx_sh_q <= {rx_sh_q[6:0], rx_bit};
        rx_cnt_q <= rx_cnt_q + 3'h1;
        rx_stage_q <= rx_bit;
      end
    end
  end
  assign uart_rx_o = uart_rx_q;

  // software registers; received data overwrites the buffer
  logic irq_set;
  assign irq_set = tx_load || rx_byte_done || rx_bit_done;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      radio_data_buffer_q <= RST_BUF;
      modem_rate_format_control_q <= RST_MODEM;
      ctrl_q <= RST_CTRL;
    end else if (ce_i) begin
      if (wr_modem) begin
        modem_rate_format_control_q <= dat_i[7:0];
      end
      if (wr_ctrl) begin
        ctrl_q <= dat_i[7:0] & CTRL_MASK;
      end
      if (rx_byte_done) begin
        radio_data_buffer_q <= {rx_sh_q[6:0], rx_bit};
      end else if (rx_bit_done) begin
        radio_data_buffer_q[0] <= rx_stage_q;
      end else if (rx_run && is_trans) begin
        radio_data_buffer_q[0] <= rx_s2_q;
      end else if (wr_buf) begin
        radio_data_buffer_q <= dat_i[7:0];
      end
    end
  end

  // sticky flags, cleared by writing one; a new event beats the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      radio_irq_flag_q <= 1'b0;
      coding_violation_flag_q <= 1'b0;
    end else if (ce_i) begin
      if (irq_set) begin
        radio_irq_flag_q <= 1'b1;
      end else if (wr_stat && dat_i[STAT_IRQ]) begin
        radio_irq_flag_q <= 1'b0;
      end
      if (rx_viol) begin
        coding_violation_flag_q <= 1'b1;
      end else if (wr_stat && dat_i[STAT_VIOL]) begin
        coding_violation_flag_q <= 1'b0;
      end
    end
  end

  assign irq_o = radio_irq_flag_q && radio_irq_enable;

  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_irq_gate_out: assert property (
    irq_o |-> radio_irq_flag_q && ctrl_q[CTRL_IEN])
    else $error("interrupt out without enabled flag");

  a_tx_load_flag: assert property (
    tx_load |=> radio_irq_flag_q)
    else $error("transmit reload did not raise the flag");

  a_tx_keeps_buf: assert property (
    tx_load && !wr_buf && !rx_run |=>
      radio_data_buffer_q == $past(radio_data_buffer_q))
    else $error("buffer changed by a transmit reload");

  a_tx_byte_load: assert property (
    tx_load && byte_transfer_select |=>
      tx_sh_q == $past(radio_data_buffer_q))
    else $error("shifter not loaded from buffer");

  a_tx_bit_load: assert property (
    tx_load && !byte_transfer_select |=>
      tx_sh_q[7] == $past(radio_data_buffer_q[0]))
    else $error("bit mode did not take buffer bit 0");

  a_powerup_load: assert property (
    ce_i && tx_go && tx_state_q == TX_OFF |-> tx_load ##1
      tx_state_q == TX_RUN)
    else $error("power up did not load at once");

  a_rx_byte_buf: assert property (
    rx_byte_done |=> radio_data_buffer_q ==
      {$past(rx_sh_q[6:0]), $past(rx_bit)} ##0 radio_irq_flag_q)
    else $error("received byte not moved to buffer");

  a_rx_bit_buf: assert property (
    rx_bit_done |=> radio_data_buffer_q[0] == $past(rx_stage_q))
    else $error("previous bit not moved to buffer bit 0");

  a_uart_bypass: assert property (
    ce_i && tx_run && is_uart && !wr_modem && !wr_ctrl |=>
      tx_mod_o == $past(uart_tx_i))
    else $error("uart data not routed to modulator");

  a_manch_viol: assert property (
    rx_viol |=> coding_violation_flag_q)
    else $error("coding violation not flagged");
endmodule
`default_nettype wire

// ---- verif/rmb_radio_model.sv ----
// far-side demodulator model that drives the receive data line
`timescale 1ns/10ps
`default_nettype none
module rmb_radio_model (
  input wire logic clk_i,
  input wire logic en_i,
  input wire logic lvl_i,
  input wire logic [7:0] pat_i,
  input wire logic [7:0] per_i,
  output logic rx_demod_o
);
  logic [7:0] sh_q = 8'h00;
  logic [7:0] cur;
  int cnt = 0;
  int bit_n = 0;
  initial rx_demod_o = 1'b0;
  // a new pattern is taken only at a byte boundary
  assign cur = (bit_n == 0) ? pat_i : sh_q;
  // repeat the pattern msb first, one bit a period; else hold a level
  always @(posedge clk_i) begin
    if (!en_i) begin
      rx_demod_o <= lvl_i;
      cnt <= 0;
      bit_n <= 0;
    end else if (cnt == 0) begin
      rx_demod_o <= cur[7];
      sh_q <= {cur[6:0], 1'b0};
      bit_n <= (bit_n + 1) % 8;
      cnt <= int'(per_i) - 1;
    end else begin
      cnt <= cnt - 1;
    end
  end
endmodule
`default_nettype wire

// ---- verif/rmb_modem_tb.sv ----
// self-checking bench for the radio modem data path
`timescale 1ns/10ps
`default_nettype none
module rmb_modem_tb
  import rmb_pkg::*;
;
  localparam logic [11:0] A_BUF = {IDX_BUF, 2'b00};
  localparam logic [11:0] A_MOD = {IDX_MODEM, 2'b00};
  localparam logic [11:0] A_CTL = {IDX_CTRL, 2'b00};
  localparam logic [11:0] A_STA = {IDX_STAT, 2'b00};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic uart_tx = 1'b1;
  logic ce = 1'b1;
  logic m_en = 1'b0;
  logic m_lvl = 1'b0;
  logic [3:0] sel = 4'h1;
  logic [11:0] adr = 12'h000;
  logic [31:0] wdat = 32'h0;
  logic [7:0] m_pat = 8'h00;
  logic [7:0] q;
  wire logic [31:0] rdat;
  wire logic ack, irq, tx_mod, rx_demod, uart_rx;
  int error_cnt = 0;
  int n_tests = 0;
  int cc = 0;

  initial begin
    forever #25 clk_i = ~clk_i;
  end

  rmb_modem #(.BASE_DIV(48)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .adr_i(adr),
    .dat_i(wdat), .dat_o(rdat), .we_i(we), .sel_i(sel), .cyc_i(cyc),
    .stb_i(stb), .ack_o(ack), .irq_o(irq), .tx_mod_o(tx_mod),
    .rx_demod_i(rx_demod), .uart_tx_i(uart_tx), .uart_rx_o(uart_rx)
  );

  rmb_radio_model mdl (
    .clk_i(clk_i), .en_i(m_en), .lvl_i(m_lvl), .pat_i(m_pat),
    .per_i(8'd24), .rx_demod_o(rx_demod)
  );

  task summarize;
    $display("errors=%0d checks=%0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // cycle count and hang guard
  always @(posedge clk_i) begin
    cc <= cc + 1;
    if (cc == 6000) begin
      error_cnt++;
      summarize();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one classic cycle; held until ack is sampled, read data kept in q
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic at(input int t);
    while (cc < t) @(posedge clk_i);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // true when v is a rotation of pattern p
  function automatic logic rot(input logic [7:0] v, input logic [7:0] p);
    logic [15:0] pp;
    pp = {p, p};
    rot = 1'b0;
    for (int k = 0; k < 8; k++) begin
      if (pp[k +: 8] === v) rot = 1'b1;
    end
  endfunction

  // reset values, read-back, unmapped place, control mask
  task t_regs;
    bus(0, A_BUF, 8'h00);
    chk(q, RST_BUF);
    bus(0, A_MOD, 8'h00);
    chk(q, RST_MODEM);
    bus(0, A_CTL, 8'h00);
    chk(q, RST_CTRL);
    bus(0, A_STA, 8'h00);
    chk(q, 8'h00);
    bus(1, A_MOD, 8'he5);
    bus(0, A_MOD, 8'h00);
    chk(q, 8'he5);
    bus(1, 12'h004, 8'hff);
    bus(0, 12'h004, 8'h00);
    chk(q, 8'h00);
    bus(1, A_CTL, 8'hff);
    bus(0, A_CTL, 8'h00);
    chk(q, CTRL_MASK);
    bus(1, A_CTL, RST_CTRL);
  endtask

  // manchester bit mode with unused codes clamped: 6-cycle chips
  task t_manch_bit;
    int t0;
    bus(1, A_MOD, 8'hcf);
    bus(1, A_BUF, 8'h01);
    bus(1, A_CTL, 8'h08);
    t0 = cc + 40;
    while (tx_mod !== 1'b1 && cc < t0) @(posedge clk_i);
    t0 = cc;
    at(t0 + 3);
    chk({7'h0, tx_mod}, 8'h01);
    at(t0 + 9);
    chk({7'h0, tx_mod}, 8'h00);
    bus(1, A_BUF, 8'h00);
    at(t0 + 51);
    chk({7'h0, tx_mod}, 8'h00);
    at(t0 + 57);
    chk({7'h0, tx_mod}, 8'h01);
    chk({7'h0, irq}, 8'h00);
    bus(0, A_STA, 8'h00);
    chk(q & 8'h01, 8'h01);
    bus(1, A_CTL, 8'h06);
  endtask

  // nrz byte mode at rate 2, crystal 1: 24-cycle bits, two bytes
  task t_tx_byte;
    int t0;
    logic [7:0] b;
    b = 8'ha5;
    bus(1, A_MOD, 8'h41);
    bus(1, A_BUF, b);
    bus(1, A_CTL, 8'h19);
    t0 = cc + 20;
    while (irq !== 1'b1 && cc < t0) @(posedge clk_i);
    chk({7'h0, irq}, 8'h01);
    t0 = cc;
    bus(1, A_STA, 8'h01);
    for (int i = 0; i < 16; i++) begin
      at(t0 + 12 + i * 24);
      chk({7'h0, tx_mod}, {7'h0, b[7 - i % 8]});
      if (i == 1) chk({7'h0, irq}, 8'h00);
      if (i == 8) begin
        chk({7'h0, irq}, 8'h01);
        bus(0, A_BUF, 8'h00);
        chk(q, b);
      end
    end
    wt(24);
    bus(1, A_CTL, 8'h06);
  endtask

  // top rate code 5 on crystal code 1: 2-cycle bits, 16-cycle bytes
  task t_fast;
    int t0;
    bus(1, A_MOD, 8'ha1);
    bus(1, A_BUF, 8'hf0);
    bus(1, A_CTL, 8'h09);
    t0 = cc + 40;
    while (tx_mod !== 1'b1 && cc < t0) @(posedge clk_i);
    while (tx_mod !== 1'b0 && cc < t0) @(posedge clk_i);
    while (tx_mod !== 1'b1 && cc < t0) @(posedge clk_i);
    t0 = cc;
    at(t0 + 4);
    chk({7'h0, tx_mod}, 8'h01);
    at(t0 + 10);
    chk({7'h0, tx_mod}, 8'h00);
    at(t0 + 17);
    chk({7'h0, tx_mod}, 8'h01);
    bus(1, A_CTL, 8'h06);
  endtask

  // transparent and uart routing in both directions
  task t_pass;
    bus(1, A_MOD, 8'h10);
    bus(1, A_CTL, 8'h08);
    for (int v = 0; v < 2; v++) begin
      bus(1, A_BUF, 8'(v));
      wt(3);
      chk({7'h0, tx_mod}, 8'(v));
    end
    bus(1, A_CTL, 8'h00);
    for (int v = 0; v < 2; v++) begin
      m_lvl <= v[0];
      wt(6);
      bus(0, A_BUF, 8'h00);
      chk(q & 8'h01, 8'(v));
    end
    bus(1, A_MOD, 8'h18);
    bus(1, A_CTL, 8'h08);
    for (int v = 0; v < 2; v++) begin
      uart_tx <= v[0];
      wt(3);
      chk({7'h0, tx_mod}, 8'(v));
    end
    // clock enable low freezes the modulator output
    ce <= 1'b0;
    uart_tx <= 1'b0;
    wt(3);
    chk({7'h0, tx_mod}, 8'h01);
    ce <= 1'b1;
    wt(3);
    chk({7'h0, tx_mod}, 8'h00);
    uart_tx <= 1'b1;
    bus(1, A_CTL, 8'h00);
    for (int v = 0; v < 2; v++) begin
      m_lvl <= v[0];
      wt(6);
      chk({7'h0, uart_rx}, 8'(v));
    end
  endtask

  // nrz byte receive of a repeated pattern, then an unread overwrite
  task t_rx_byte;
    int t0;
    bus(1, A_MOD, 8'h41);
    m_pat <= 8'h17;
    m_en <= 1'b1;
    bus(1, A_CTL, 8'h11);
    wt(200);
    bus(1, A_STA, 8'h01);
    t0 = cc + 250;
    while (irq !== 1'b1 && cc < t0) @(posedge clk_i);
    chk({7'h0, irq}, 8'h01);
    bus(0, A_BUF, 8'h00);
    chk({7'h0, rot(q, 8'h17)}, 8'h01);
    m_pat <= 8'h01;
    wt(800);
    bus(0, A_BUF, 8'h00);
    chk({7'h0, rot(q, 8'h01)}, 8'h01);
    m_en <= 1'b0;
  endtask

  // manchester receive of a constant line: equal chips every bit
  task t_viol;
    bus(1, A_MOD, 8'h68);
    m_lvl <= 1'b1;
    bus(1, A_CTL, 8'h01);
    bus(1, A_STA, 8'h03);
    wt(150);
    bus(0, A_STA, 8'h00);
    chk(q & 8'h03, 8'h03);
    chk({7'h0, irq}, 8'h00);
    bus(1, A_CTL, 8'h06);
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_manch_bit();
    t_tx_byte();
    t_fast();
    t_pass();
    t_rx_byte();
    t_viol();
    summarize();
  end
endmodule
`default_nettype wire
